// [logic/acr_byte_reg.sv]
// One byte of writable register with a reset value
// Assumes a single-cycle write strobe already decoded for this byte
`default_nettype none
module acr_byte_reg
  import acr_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  logic [7:0] q_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_reg <= RESET_VAL;
    end else if (we) begin
      q_reg <= wdata;
    end
  end
  assign q = q_reg;
endmodule
`default_nettype wire

// [logic/acr_pos_capture.sv]
// Holds the latest sync edge position sample from the clock detector
// Assumes the detector strobe is synchronous to clk
`default_nettype none
module acr_pos_capture
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pos_valid,
  input wire logic [POS_W-1:0] pos_in,
  output logic [POS_W-1:0] pos
);
  logic [POS_W-1:0] pos_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_reg <= RST_SYNC_POS;
    end else if (pos_valid) begin
      pos_reg <= pos_in;
    end
  end
  assign pos = pos_reg;
endmodule
`default_nettype wire

// [logic/acr_regs.sv]
// Clock path, sync edge position, full-scale range and timestamp registers
// Assumes a plain register port and a position detector feeding pos_in
//
// Contract
// - Clock tuning resets to 0x11; bit 4 selects high converter feedback gain.
// - Clock tuning bit 2 enables supply noise suppression.
// - Clock tuning bits 1:0 hold one-hot sample delay, reset 1.
// - Read-only 24-bit sync edge position status is reported.
// - Input A full-scale code is 16 bits, reset 0xa000.
// - Input B full-scale code is 16 bits, reset 0xa000.
// - Reference select bit 0 chooses supply reference over band-gap.
// - Timestamp control bit 0 enables the timestamp receiver, reset 0.
// - Timestamp control bit 1 selects PECL mode, reset 0.
// - Four-bit sync delay select; zero allows automatic sync calibration.
`default_nettype none
module acr_regs
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic pos_valid,
  input wire logic [POS_W-1:0] pos_in,
  output acr_ctrl_type ctrl
);
  // ----------------------------------------
  // Request and decode
  // ----------------------------------------
  acr_req_type req;
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic we_clk = req.wr && hit(req.addr, OFS_CLK_TUNE);
  wire logic we_fsa_lo = req.wr && hit(req.addr, OFS_FSA_LO);
  wire logic we_fsa_hi = req.wr && hit(req.addr, OFS_FSA_HI);
  wire logic we_fsb_lo = req.wr && hit(req.addr, OFS_FSB_LO);
  wire logic we_fsb_hi = req.wr && hit(req.addr, OFS_FSB_HI);
  wire logic we_ref = req.wr && hit(req.addr, OFS_REF_SEL);
  wire logic we_ts = req.wr && hit(req.addr, OFS_TS_CTRL);
  wire logic we_sel = req.wr && hit(req.addr, OFS_SYNC_SEL);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] clk_tune;
  logic [7:0] fsa_lo;
  logic [7:0] fsa_hi;
  logic [7:0] fsb_lo;
  logic [7:0] fsb_hi;
  logic [7:0] ref_sel;
  logic [7:0] ts_ctrl;
  logic [7:0] sync_sel;
  logic [POS_W-1:0] sync_pos;

  acr_byte_reg #(.RESET_VAL(RST_CLK_TUNE)) u_clk (
    .clk(clk), .rst(rst), .we(we_clk), .wdata(req.wdata), .q(clk_tune));
  acr_byte_reg #(.RESET_VAL(RST_FULLSCALE[7:0])) u_fsa_lo (
    .clk(clk), .rst(rst), .we(we_fsa_lo), .wdata(req.wdata), .q(fsa_lo));
  acr_byte_reg #(.RESET_VAL(RST_FULLSCALE[15:8])) u_fsa_hi (
    .clk(clk), .rst(rst), .we(we_fsa_hi), .wdata(req.wdata), .q(fsa_hi));
  acr_byte_reg #(.RESET_VAL(RST_FULLSCALE[7:0])) u_fsb_lo (
    .clk(clk), .rst(rst), .we(we_fsb_lo), .wdata(req.wdata), .q(fsb_lo));
  acr_byte_reg #(.RESET_VAL(RST_FULLSCALE[15:8])) u_fsb_hi (
    .clk(clk), .rst(rst), .we(we_fsb_hi), .wdata(req.wdata), .q(fsb_hi));
  acr_byte_reg #(.RESET_VAL(RST_REF_SEL)) u_ref (
    .clk(clk), .rst(rst), .we(we_ref), .wdata(req.wdata), .q(ref_sel));
  acr_byte_reg #(.RESET_VAL(RST_TS_CTRL)) u_ts (
    .clk(clk), .rst(rst), .we(we_ts), .wdata(req.wdata), .q(ts_ctrl));
  acr_byte_reg #(.RESET_VAL(RST_SYNC_SEL)) u_sel (
    .clk(clk), .rst(rst), .we(we_sel), .wdata(req.wdata), .q(sync_sel));

  acr_pos_capture u_pos (
    .clk(clk), .rst(rst), .pos_valid(pos_valid), .pos_in(pos_in), .pos(sync_pos));

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  acr_ctrl_type ctrl_next;
  acr_ctrl_type ctrl_reg;
  always_comb begin
    ctrl_next.fb_gain_high = clk_tune[BIT_FB_GAIN];
    ctrl_next.noise_suppress = clk_tune[BIT_NOISE_SUPPR];
    ctrl_next.sample_delay = clk_tune[BIT_DELAY_HI:0];
    ctrl_next.ref_from_supply = ref_sel[BIT_REF_BYPASS];
    ctrl_next.ts_receiver_enable = ts_ctrl[BIT_TS_RECV];
    ctrl_next.ts_pecl_mode = ts_ctrl[BIT_TS_PECL];
    ctrl_next.sync_delay_select = sync_sel[SEL_W-1:0];
    ctrl_next.sync_auto_cal_allowed = (sync_sel[SEL_W-1:0] == '0);
    ctrl_next.fullscale_a = {fsa_hi, fsa_lo};
    ctrl_next.fullscale_b = {fsb_hi, fsb_lo};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= '{fb_gain_high: RST_CLK_TUNE[BIT_FB_GAIN],
                    noise_suppress: RST_CLK_TUNE[BIT_NOISE_SUPPR],
                    sample_delay: RST_CLK_TUNE[BIT_DELAY_HI:0],
                    ref_from_supply: RST_REF_SEL[BIT_REF_BYPASS],
                    ts_receiver_enable: RST_TS_CTRL[BIT_TS_RECV],
                    ts_pecl_mode: RST_TS_CTRL[BIT_TS_PECL],
                    sync_delay_select: RST_SYNC_SEL[SEL_W-1:0],
                    sync_auto_cal_allowed: 1'b1,
                    fullscale_a: RST_FULLSCALE,
                    fullscale_b: RST_FULLSCALE};
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end
  assign ctrl = ctrl_reg;

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (req.addr)
      OFS_CLK_TUNE: rd_mux = clk_tune;
      OFS_SYNC_POS0: rd_mux = sync_pos[7:0];
      OFS_SYNC_POS1: rd_mux = sync_pos[15:8];
      OFS_SYNC_POS2: rd_mux = sync_pos[23:16];
      OFS_FSA_LO: rd_mux = fsa_lo;
      OFS_FSA_HI: rd_mux = fsa_hi;
      OFS_FSB_LO: rd_mux = fsb_lo;
      OFS_FSB_HI: rd_mux = fsb_hi;
      OFS_REF_SEL: rd_mux = ref_sel;
      OFS_TS_CTRL: rd_mux = ts_ctrl;
      OFS_SYNC_SEL: rd_mux = sync_sel;
      default: rd_mux = READ_UNMAPPED;
    endcase
  end

  logic [7:0] rdata_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= READ_UNMAPPED;
    end else if (req.rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= READ_UNMAPPED;
    end
  end
  assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

// [shared/acr_pkg.sv]
// Constants and types for the converter clock and range register bank
// Assumes a byte-wide register port with byte offsets as printed
`default_nettype none
package acr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets (byte addresses of an 8-bit register space)
  localparam logic [7:0] OFS_CLK_TUNE = 8'h2b;
  localparam logic [7:0] OFS_SYNC_POS0 = 8'h2c;
  localparam logic [7:0] OFS_SYNC_POS1 = 8'h2d;
  localparam logic [7:0] OFS_SYNC_POS2 = 8'h2e;
  localparam logic [7:0] OFS_FSA_LO = 8'h30;
  localparam logic [7:0] OFS_FSA_HI = 8'h31;
  localparam logic [7:0] OFS_FSB_LO = 8'h32;
  localparam logic [7:0] OFS_FSB_HI = 8'h33;
  localparam logic [7:0] OFS_REF_SEL = 8'h38;
  localparam logic [7:0] OFS_TS_CTRL = 8'h3b;
  localparam logic [7:0] OFS_SYNC_SEL = 8'h3c;
  // Reset values
  localparam logic [7:0] RST_CLK_TUNE = 8'h11;
  localparam logic [15:0] RST_FULLSCALE = 16'ha000;
  localparam logic [7:0] RST_REF_SEL = 8'h00;
  localparam logic [7:0] RST_TS_CTRL = 8'h00;
  localparam logic [7:0] RST_SYNC_SEL = 8'h00;
  localparam logic [23:0] RST_SYNC_POS = 24'h000000;
  // Field positions
  localparam int BIT_FB_GAIN = 4;
  localparam int BIT_NOISE_SUPPR = 2;
  localparam int BIT_DELAY_HI = 1;
  localparam int BIT_REF_BYPASS = 0;
  localparam int BIT_TS_RECV = 0;
  localparam int BIT_TS_PECL = 1;
  localparam int SEL_W = 4;
  localparam int POS_W = 24;
  localparam int FS_W = 16;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } acr_req_type;

  typedef struct packed {
    logic fb_gain_high;
    logic noise_suppress;
    logic [1:0] sample_delay;
    logic ref_from_supply;
    logic ts_receiver_enable;
    logic ts_pecl_mode;
    logic [SEL_W-1:0] sync_delay_select;
    logic sync_auto_cal_allowed;
    logic [FS_W-1:0] fullscale_a;
    logic [FS_W-1:0] fullscale_b;
  } acr_ctrl_type;
endpackage
`default_nettype wire

// [tb/acr_regs_checker.sv]
// Assertions on the register bank ports
// Sees only the ports of acr_regs; bound to it at the foot
`default_nettype none
module acr_regs_checker
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic pos_valid,
  input wire logic [POS_W-1:0] pos_in,
  input wire acr_ctrl_type ctrl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_wr(a, got, exp);
    reg_wr && reg_addr == a |-> ##2 got == exp;
  endproperty
  AST_FB_GAIN: assert property (p_wr(OFS_CLK_TUNE, ctrl.fb_gain_high, $past(reg_wdata[4], 2)))
    else $error("gain field wrong");
  AST_NOISE: assert property (p_wr(OFS_CLK_TUNE, ctrl.noise_suppress, $past(reg_wdata[2], 2)))
    else $error("noise field wrong");
  AST_DELAY: assert property (p_wr(OFS_CLK_TUNE, ctrl.sample_delay, $past(reg_wdata[1:0], 2)))
    else $error("delay field wrong");
  AST_FSA_LO: assert property (p_wr(OFS_FSA_LO, ctrl.fullscale_a[7:0], $past(reg_wdata, 2)))
    else $error("range a wrong");
  AST_FSB_HI: assert property (p_wr(OFS_FSB_HI, ctrl.fullscale_b[15:8], $past(reg_wdata, 2)))
    else $error("range b wrong");
  AST_REF: assert property (p_wr(OFS_REF_SEL, ctrl.ref_from_supply, $past(reg_wdata[0], 2)))
    else $error("reference wrong");
  AST_TS: assert property (reg_wr && reg_addr == OFS_TS_CTRL |-> ##2
    {ctrl.ts_pecl_mode, ctrl.ts_receiver_enable} == $past(reg_wdata[1:0], 2))
    else $error("timestamp wrong");
  AST_AUTOCAL: assert property (ctrl.sync_auto_cal_allowed == (ctrl.sync_delay_select == 4'h0))
    else $error("auto cal wrong");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_HOLD: assert property (!reg_wr [*3] |-> $stable(ctrl))
    else $error("control moved");
  cover property (reg_wr && reg_addr == OFS_CLK_TUNE);
  cover property (reg_rd && reg_addr == OFS_SYNC_POS2);
  cover property (pos_valid ##1 reg_rd);
endmodule
bind acr_regs acr_regs_checker i_acr_regs_checker (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pos_valid(pos_valid), .pos_in(pos_in), .ctrl(ctrl));
`default_nettype wire

// [tb/acr_regs_test.sv]
// Self-checking bench for the register bank against a byte model
// Drives the register port and position strobe directly
`default_nettype none
module acr_regs_test
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pos_valid = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, m [0:255];
  logic [23:0] pos_in = 24'h000000;
  acr_ctrl_type ctrl;
  int fails = 0, samples_checked = 0, seed = 74, cycles = 0;
  logic [7:0] addrs [13] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h30, 8'h31, 8'h32, 8'h33,
    8'h38, 8'h3b, 8'h3c, 8'h2a, 8'hff};
  acr_regs i_acr_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_valid(pos_valid),
    .pos_in(pos_in), .ctrl(ctrl));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic model_reset();
    foreach (m[i]) m[i] = 8'h00;
    m[8'h2b] = RST_CLK_TUNE;
    m[8'h31] = RST_FULLSCALE[15:8];
    m[8'h33] = RST_FULLSCALE[15:8];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a inside {8'h2b, 8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3b, 8'h3c}) m[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, m[a]);
  endtask
  task automatic check_ctrl();
    repeat (2) @(posedge clk);
    #1;
    check(ctrl.fb_gain_high, m[8'h2b][4]);
    check(ctrl.noise_suppress, m[8'h2b][2]);
    check(ctrl.sample_delay, m[8'h2b][1:0]);
    check(ctrl.ref_from_supply, m[8'h38][0]);
    check(ctrl.ts_receiver_enable, m[8'h3b][0]);
    check(ctrl.ts_pecl_mode, m[8'h3b][1]);
    check({ctrl.sync_delay_select, ctrl.sync_auto_cal_allowed},
      {m[8'h3c][3:0], m[8'h3c][3:0] == 4'h0});
    check(ctrl.fullscale_a, {m[8'h31], m[8'h30]});
    check(ctrl.fullscale_b, {m[8'h33], m[8'h32]});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [23:0] p;
    model_reset();
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 62; n++) begin
      check_ctrl();
      foreach (addrs[i]) rd(addrs[i]);
      if (n == 30) begin
        wr(8'h30, 8'h00);
        wr(8'h31, 8'h20);
        wr(8'h32, 8'hff);
        wr(8'h33, 8'hff);
      end else if (n == 45) begin
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        model_reset();
      end else begin
        wr(addrs[$unsigned($random(seed)) % 13], 8'($random(seed)));
        p = 24'($random(seed));
        @(posedge clk);
        pos_in <= p;
        pos_valid <= 1'b1;
        @(posedge clk);
        pos_valid <= 1'b0;
        {m[8'h2e], m[8'h2d], m[8'h2c]} = p;
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
